/* hdl/iapc_audio_port.sv */
// Audio port configuration and control: registers, I2S capture port,
// I2S playback port, master clock, link events.
// Assumes one core clock at 50 MHz; I2S input pins are asynchronous.
//
// How it works
// [RQ1] S/PDIF input forces master clock off
// [RQ2] Software sets clock field to expected rate
// [RQ3] Capture bit 7 clear: all pins inputs
// [RQ4] Capture bit 7 set: drive clock, select
// [RQ5] Decode length, polarity, delay, justification codes
// [RQ6] Capture data on rising bit clock only
// [RQ7] Receiver mode: power-down, radio, S/PDIF bits
// [RQ8] Playback polarity, delay, justification selectable
// [RQ9] Playback data valid edge per bit 2
// [RQ10] Receiver mode sent on link locate
// [RQ11] Playback config applies on link reconfigure
// [RQ12] Mute applies at once when received
// [RQ13] Mute zeroes samples instantly, no ramp
// [RQ14] Control channel reaches receiver registers remotely
// [RQ15] Transmit format applies on link reconfigure
// [RQ16] Software writes zero to reserved bits
`timescale 1ns/100ps
`default_nettype none

module iapc_audio_port (
	// Clock, reset, enable
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Local register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	// Radio control channel port
	input wire logic [7:0] ctl_addr_i,
	input wire logic [7:0] ctl_wdata_i,
	input wire logic ctl_wr_i,
	input wire logic ctl_rd_i,
	output logic [7:0] ctl_rdata_o,
	// Link events
	input wire logic link_reconfig_i,
	input wire logic link_locate_i,
	output logic rx_mode_xfer_valid_o,
	output logic [7:0] rx_mode_xfer_data_o,
	// Mode outputs
	output logic rx_power_down_o,
	output logic rf_enable_o,
	output logic spdif_out_en_o,
	output logic tx_compand_o,
	output logic mclk_o,
	// I2S capture pins
	input wire logic in_bclk_i,
	input wire logic in_ws_i,
	input wire logic in_sd_i,
	output logic in_bclk_o,
	output logic in_bclk_oe_o,
	output logic in_ws_o,
	output logic in_ws_oe_o,
	// I2S playback pins
	output logic out_bclk_o,
	output logic out_ws_o,
	output logic out_sd_o,
	// Buffer status
	output logic fifo_ready_o,
	output logic overrun_o
);
	////////////////////////////////////////////////////////////////////////
	// Registers
	logic [7:0] in_cfg_q, in_cfg_d, tx_mode_q, tx_mode_d, fmt_pend_q, fmt_pend_d;
	logic [7:0] fmt_act_q, fmt_act_d, rx_mode_q, rx_mode_d;
	logic [7:0] out_pend_q, out_pend_d, out_act_q, out_act_d;
	logic [7:0] rdata_q, rdata_d, crdata_q, crdata_d, xfer_q, xfer_d;
	logic xfer_v_q, xfer_v_d, ctl_ok, wr_en;
	logic [7:0] wr_addr, wr_data;
	localparam logic [7:0] REG_RESET_V = iapc_pkg::REG_RESET;

	function automatic logic [7:0] read_map(input logic [7:0] a, input logic remote,
		input logic [7:0] rxm, input logic [7:0] ocfg, input logic [7:0] icfg,
		input logic [7:0] txm, input logic [7:0] fmt);
		read_map = REG_RESET_V;
		case (a)
			iapc_pkg::ADDR_RX_MODE: read_map = rxm;
			iapc_pkg::ADDR_OUT_CFG: read_map = ocfg;
			iapc_pkg::ADDR_IN_CFG: read_map = remote ? REG_RESET_V : icfg;
			iapc_pkg::ADDR_TX_MODE: read_map = remote ? REG_RESET_V : txm;
			iapc_pkg::ADDR_TX_FMT: read_map = remote ? REG_RESET_V : fmt;
			default: read_map = REG_RESET_V;
		endcase
	endfunction

	always_comb begin
		in_cfg_d = in_cfg_q;
		tx_mode_d = tx_mode_q;
		fmt_pend_d = fmt_pend_q;
		fmt_act_d = fmt_act_q;
		rx_mode_d = rx_mode_q;
		out_pend_d = out_pend_q;
		out_act_d = out_act_q;
		// Only receiver registers are reachable remotely; local port wins
		ctl_ok = (ctl_addr_i == iapc_pkg::ADDR_RX_MODE) ||
			(ctl_addr_i == iapc_pkg::ADDR_OUT_CFG); // [RQ14]
		wr_en = reg_wr_i || (ctl_wr_i && ctl_ok);
		wr_addr = reg_wr_i ? reg_addr_i : ctl_addr_i;
		wr_data = reg_wr_i ? reg_wdata_i : ctl_wdata_i;
		if (wr_en) begin
			case (wr_addr)
				iapc_pkg::ADDR_IN_CFG: in_cfg_d = wr_data & iapc_pkg::IN_CFG_MASK; // [RQ5]
				iapc_pkg::ADDR_TX_MODE: tx_mode_d = wr_data & iapc_pkg::TX_MODE_MASK;
				iapc_pkg::ADDR_TX_FMT: fmt_pend_d = wr_data & iapc_pkg::TX_FMT_MASK;
				iapc_pkg::ADDR_RX_MODE: rx_mode_d = wr_data & iapc_pkg::RX_MODE_MASK; // [RQ7]
				iapc_pkg::ADDR_OUT_CFG: out_pend_d = wr_data & iapc_pkg::OUT_CFG_MASK; // [RQ8]
				default: ;
			endcase
		end
		out_act_d[iapc_pkg::MUTE_BIT] = out_pend_d[iapc_pkg::MUTE_BIT]; // [RQ12]
		if (link_reconfig_i) begin
			out_act_d = out_pend_d; // [RQ11]
			fmt_act_d = fmt_pend_d; // [RQ15]
		end
		rdata_d = reg_rd_i ? read_map(reg_addr_i, 1'b0, rx_mode_q, out_pend_q, in_cfg_q,
			tx_mode_q, fmt_pend_q) : rdata_q;
		crdata_d = ctl_rd_i ? read_map(ctl_addr_i, 1'b1, rx_mode_q, out_pend_q, in_cfg_q,
			tx_mode_q, fmt_pend_q) : crdata_q; // [RQ14]
		xfer_v_d = link_locate_i; // [RQ10]
		xfer_d = link_locate_i ? rx_mode_q : xfer_q;
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			in_cfg_q <= iapc_pkg::REG_RESET;
			tx_mode_q <= iapc_pkg::REG_RESET;
			fmt_pend_q <= iapc_pkg::REG_RESET;
			fmt_act_q <= iapc_pkg::REG_RESET;
			rx_mode_q <= iapc_pkg::REG_RESET;
			out_pend_q <= iapc_pkg::REG_RESET;
			out_act_q <= iapc_pkg::REG_RESET;
			rdata_q <= iapc_pkg::REG_RESET;
			crdata_q <= iapc_pkg::REG_RESET;
			xfer_q <= iapc_pkg::REG_RESET;
			xfer_v_q <= 1'b0;
		end else if (ce_i) begin
			in_cfg_q <= in_cfg_d;
			tx_mode_q <= tx_mode_d;
			fmt_pend_q <= fmt_pend_d;
			fmt_act_q <= fmt_act_d;
			rx_mode_q <= rx_mode_d;
			out_pend_q <= out_pend_d;
			out_act_q <= out_act_d;
			rdata_q <= rdata_d;
			crdata_q <= crdata_d;
			xfer_q <= xfer_d;
			xfer_v_q <= xfer_v_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Master clock and shared bit-clock timebase
	logic [3:0] mc_cnt_q, mc_cnt_d, mc_half, hc_q, hc_d;
	logic mclk_q, mclk_d, mc_off, hc_wrap;
	logic [1:0] mc_rate;

	always_comb begin
		mc_rate = tx_mode_q[iapc_pkg::TXM_MCLK_HI:iapc_pkg::TXM_MCLK_LO];
		case (mc_rate)
			iapc_pkg::MCLK_48K: mc_half = iapc_pkg::MCLK_48K_HALF;
			iapc_pkg::MCLK_44K: mc_half = iapc_pkg::MCLK_44K_HALF;
			default: mc_half = iapc_pkg::MCLK_32K_HALF;
		endcase
		mc_off = tx_mode_q[iapc_pkg::TXM_SPDIF_BIT] || (mc_rate == iapc_pkg::MCLK_OFF); // [RQ1]
		mc_cnt_d = 4'(mc_cnt_q + 1'b1);
		mclk_d = mclk_q;
		if (mc_off) begin
			mc_cnt_d = '0;
			mclk_d = 1'b0; // [RQ1]
		end else if (mc_cnt_d >= mc_half) begin
			mc_cnt_d = '0;
			mclk_d = ~mclk_q;
		end
		hc_wrap = (hc_q == 4'(iapc_pkg::BCLK_HALF_CYC - 1'b1));
		hc_d = hc_wrap ? '0 : 4'(hc_q + 1'b1);
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			mc_cnt_q <= '0;
			mclk_q <= 1'b0;
			hc_q <= '0;
		end else if (ce_i) begin
			mc_cnt_q <= mc_cnt_d;
			mclk_q <= mclk_d;
			hc_q <= hc_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// I2S capture port
	logic [2:0] pin_lvl;
	logic in_master, ibclk_q, ibclk_d, iws_q, iws_d, bprev_q, bprev_d;
	logic bit_evt, ws_now, wsp_q, wsp_d, push_w, pws, len24, len_ok, ovr_q, ovr_d;
	logic [4:0] ipos_q, ipos_d, cnt_q, cnt_d, nbits;
	logic [23:0] sh_q, sh_d, shifted, pword;
	logic [1:0] len_code;
	logic fifo_in_ready, fifo_out_valid, pop_w, fready_q;
	logic [iapc_pkg::FIFO_W-1:0] fifo_in_data, fifo_out_data;

	iapc_sync #(.W(3)) u_sync (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.pin_i({in_bclk_i, in_ws_i, in_sd_i}),
		.level_o(pin_lvl)
	);

	always_comb begin
		in_master = in_cfg_q[iapc_pkg::MASTER_BIT];
		len_code = in_cfg_q[iapc_pkg::LEN_HI:iapc_pkg::LEN_LO];
		len24 = (len_code == iapc_pkg::LEN_24); // [RQ5]
		len_ok = len24 || (len_code == iapc_pkg::LEN_16);
		nbits = len24 ? iapc_pkg::BITS_24 : iapc_pkg::BITS_16;
		// Own clock and select follow the next mode; no stale clock in slave
		ibclk_d = 1'b0;
		iws_d = 1'b0;
		ipos_d = iapc_pkg::SLOT_LAST;
		if (in_cfg_d[iapc_pkg::MASTER_BIT]) begin // [RQ4]
			ibclk_d = hc_wrap ? ~ibclk_q : ibclk_q;
			iws_d = iws_q;
			ipos_d = ipos_q;
			if (hc_wrap && ibclk_q) begin
				ipos_d = 5'(ipos_q + 1'b1);
				if (ipos_q == iapc_pkg::SLOT_LAST)
					iws_d = ~iws_q;
			end
		end
		bprev_d = pin_lvl[2];
		// Sample on rising bit clock only; edge bit is ignored
		bit_evt = in_master ? (hc_wrap && !ibclk_q) : (pin_lvl[2] && !bprev_q); // [RQ6] [RQ3]
		ws_now = in_master ? iws_q : pin_lvl[1];
		shifted = {sh_q[22:0], pin_lvl[0]};
		sh_d = sh_q;
		cnt_d = cnt_q;
		wsp_d = wsp_q;
		push_w = 1'b0;
		pword = shifted;
		pws = ws_now;
		if (bit_evt) begin
			sh_d = shifted;
			wsp_d = ws_now;
			pws = wsp_q;
			if (ws_now != wsp_q) begin
				push_w = in_cfg_q[iapc_pkg::JUST_BIT];
				if (in_cfg_q[iapc_pkg::DELAY_BIT]) begin // [RQ5]
					pword = sh_q;
					cnt_d = 5'h01;
				end else begin
					cnt_d = '0;
				end
			end else begin
				pws = ws_now;
				cnt_d = (cnt_q == iapc_pkg::SLOT_LAST) ? cnt_q : 5'(cnt_q + 1'b1);
				push_w = !in_cfg_q[iapc_pkg::JUST_BIT] && (5'(cnt_q + 1'b1) == nbits);
			end
			push_w = push_w && len_ok; // [RQ5]
		end
		fifo_in_data = {pws == in_cfg_q[iapc_pkg::POL_BIT],
			len24 ? pword : {pword[15:0], iapc_pkg::PAD_ZERO}}; // [RQ5]
		ovr_d = ovr_q || (push_w && !fifo_in_ready);
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			ibclk_q <= 1'b0;
			iws_q <= 1'b0;
			ipos_q <= iapc_pkg::SLOT_LAST;
			bprev_q <= 1'b0;
			sh_q <= '0;
			cnt_q <= '0;
			wsp_q <= 1'b0;
			ovr_q <= 1'b0;
			fready_q <= 1'b0;
		end else if (ce_i) begin
			ibclk_q <= ibclk_d;
			iws_q <= iws_d;
			ipos_q <= ipos_d;
			bprev_q <= bprev_d;
			sh_q <= sh_d;
			cnt_q <= cnt_d;
			wsp_q <= wsp_d;
			ovr_q <= ovr_d;
			fready_q <= fifo_in_ready;
		end
	end

	iapc_fifo #(.W(iapc_pkg::FIFO_W), .DEPTH(iapc_pkg::FIFO_DEPTH)) u_fifo (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.in_valid_i(push_w),
		.in_data_i(fifo_in_data),
		.in_ready_o(fifo_in_ready),
		.out_valid_o(fifo_out_valid),
		.out_data_o(fifo_out_data),
		.out_ready_i(pop_w)
	);

	////////////////////////////////////////////////////////////////////////
	// I2S playback port
	iapc_pkg::iapc_out_state_e ost_q, ost_d;
	logic obclk_q, obclk_d, ows_q, ows_d, osd_q, osd_d, ochl_q, ochl_d, launch;
	logic [4:0] opos_q, opos_d, oq;
	logic [23:0] oword_q, oword_d;
	logic [31:0] oslot;

	always_comb begin
		ost_d = ost_q;
		obclk_d = obclk_q;
		ows_d = ows_q;
		osd_d = osd_q;
		ochl_d = ochl_q;
		opos_d = opos_q;
		oword_d = oword_q;
		pop_w = 1'b0;
		oq = '0;
		oslot = '0;
		// Launch on the edge opposite the valid edge
		launch = hc_wrap && (obclk_q != out_act_q[iapc_pkg::EDGE_BIT]); // [RQ9]
		case (ost_q)
			iapc_pkg::OUT_IDLE: begin
				obclk_d = 1'b0;
				ows_d = 1'b0;
				osd_d = 1'b0;
				ochl_d = 1'b0;
				opos_d = iapc_pkg::SLOT_LAST;
				if (!rx_mode_q[iapc_pkg::RXM_PD_BIT] && hc_wrap)
					ost_d = iapc_pkg::OUT_RUN;
			end
			iapc_pkg::OUT_RUN: begin
				if (hc_wrap)
					obclk_d = ~obclk_q;
				if (launch) begin
					opos_d = 5'(opos_q + 1'b1);
					if (opos_d == '0)
						ochl_d = ~ochl_q;
					oq = out_act_q[iapc_pkg::DELAY_BIT] ? opos_d : 5'(opos_d - 1'b1); // [RQ8]
					if (oq == '0) begin
						pop_w = fifo_out_valid;
						oword_d = (fifo_out_valid && fifo_out_data[iapc_pkg::SAMPLE_W] == ochl_d) ?
							fifo_out_data[iapc_pkg::SAMPLE_W-1:0] : '0;
					end
					oslot = out_act_q[iapc_pkg::JUST_BIT] ? {iapc_pkg::PAD_ZERO, oword_d} :
						{oword_d, iapc_pkg::PAD_ZERO}; // [RQ8]
					osd_d = out_act_q[iapc_pkg::MUTE_BIT] ? 1'b0 : oslot[5'(iapc_pkg::SLOT_LAST - oq)]; // [RQ13]
					ows_d = ochl_d ? out_act_q[iapc_pkg::POL_BIT] : ~out_act_q[iapc_pkg::POL_BIT]; // [RQ8]
				end
				if (rx_mode_q[iapc_pkg::RXM_PD_BIT])
					ost_d = iapc_pkg::OUT_IDLE;
			end
			default: ost_d = iapc_pkg::OUT_IDLE;
		endcase
		// Mute clears the pin within a cycle, not at the next bit
		if (out_act_d[iapc_pkg::MUTE_BIT])
			osd_d = 1'b0; // [RQ13]
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			ost_q <= iapc_pkg::OUT_IDLE;
			obclk_q <= 1'b0;
			ows_q <= 1'b0;
			osd_q <= 1'b0;
			ochl_q <= 1'b0;
			opos_q <= iapc_pkg::SLOT_LAST;
			oword_q <= '0;
		end else if (ce_i) begin
			ost_q <= ost_d;
			obclk_q <= obclk_d;
			ows_q <= ows_d;
			osd_q <= osd_d;
			ochl_q <= ochl_d;
			opos_q <= opos_d;
			oword_q <= oword_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign reg_rdata_o = rdata_q;
	assign ctl_rdata_o = crdata_q;
	assign rx_mode_xfer_valid_o = xfer_v_q;
	assign rx_mode_xfer_data_o = xfer_q;
	assign rx_power_down_o = rx_mode_q[iapc_pkg::RXM_PD_BIT];
	assign rf_enable_o = rx_mode_q[iapc_pkg::RXM_RF_BIT];
	assign spdif_out_en_o = rx_mode_q[iapc_pkg::RXM_SPDIF_BIT];
	assign tx_compand_o = fmt_act_q[iapc_pkg::FMT_COMPAND_BIT];
	assign mclk_o = mclk_q;
	assign in_bclk_o = ibclk_q;
	assign in_ws_o = iws_q;
	assign in_bclk_oe_o = in_cfg_q[iapc_pkg::MASTER_BIT];
	assign in_ws_oe_o = in_cfg_q[iapc_pkg::MASTER_BIT];
	assign out_bclk_o = obclk_q;
	assign out_ws_o = ows_q;
	assign out_sd_o = osd_q;
	assign fifo_ready_o = fready_q;
	assign overrun_o = ovr_q;

	////////////////////////////////////////////////////////////////////////
	// Assertions
	sequence s_mute_write;
		ce_i && reg_wr_i && reg_addr_i == iapc_pkg::ADDR_OUT_CFG && reg_wdata_i[iapc_pkg::MUTE_BIT];
	endsequence
	sequence s_reconfig;
		ce_i && link_reconfig_i && !reg_wr_i && !ctl_wr_i;
	endsequence
	sequence s_remote_rxm;
		ce_i && ctl_wr_i && !reg_wr_i && ctl_addr_i == iapc_pkg::ADDR_RX_MODE;
	endsequence

	a_mclk_spdif_off: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RQ1]
		ce_i && tx_mode_q[iapc_pkg::TXM_SPDIF_BIT] |=> !mclk_o)
		else $error("master clock running with S/PDIF input");
	a_slave_pins_in: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RQ3]
		!in_cfg_q[iapc_pkg::MASTER_BIT] |-> !in_bclk_oe_o && !in_ws_oe_o && !in_bclk_o)
		else $error("slave capture port drives a pin");
	a_master_bclk_run: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RQ4]
		ce_i && in_master && hc_wrap ##1 in_master |-> in_bclk_o != $past(in_bclk_o))
		else $error("master bit clock did not toggle");
	a_len_reserved: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RQ5]
		!len_ok |-> !push_w)
		else $error("sample captured with reserved length");
	a_rise_capture: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RQ6]
		push_w && !in_master |-> pin_lvl[2] && !bprev_q)
		else $error("capture away from rising bit clock");
	a_rxmode_write: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RQ7]
		ce_i && reg_wr_i && reg_addr_i == iapc_pkg::ADDR_RX_MODE |=>
		rx_mode_q == ($past(reg_wdata_i) & iapc_pkg::RX_MODE_MASK))
		else $error("receiver mode write wrong");
	a_launch_edge: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RQ9]
		ce_i && launch && ost_q == iapc_pkg::OUT_RUN && !link_reconfig_i |=>
		out_bclk_o == out_act_q[iapc_pkg::EDGE_BIT])
		else $error("playback data launched on wrong edge");
	a_locate_xfer: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RQ10]
		ce_i && link_locate_i |=> rx_mode_xfer_valid_o && rx_mode_xfer_data_o == $past(rx_mode_q))
		else $error("receiver mode not sent on locate");
	a_out_deferred: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RQ11]
		ce_i && !link_reconfig_i |=> $stable(out_act_q[iapc_pkg::POL_BIT:0]))
		else $error("playback config applied early");
	a_reconfig_apply: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RQ11]
		s_reconfig |=> out_act_q == $past(out_pend_q))
		else $error("playback config not applied");
	a_mute_now: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RQ12]
		s_mute_write |=> out_act_q[iapc_pkg::MUTE_BIT])
		else $error("mute delayed");
	a_mute_zero: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RQ13]
		out_act_q[iapc_pkg::MUTE_BIT] |-> !out_sd_o)
		else $error("muted sample not zero");
	a_remote_write: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RQ14]
		s_remote_rxm |=> rx_mode_q == ($past(ctl_wdata_i) & iapc_pkg::RX_MODE_MASK))
		else $error("remote write lost");
	a_fmt_deferred: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RQ15]
		ce_i && !link_reconfig_i |=> $stable(tx_compand_o))
		else $error("transmit format applied early");
endmodule // iapc_audio_port

`default_nettype wire

/* hdl/iapc_fifo.sv */
// Flip-flop FIFO with valid/ready on both sides.
// Same clock on both sides; ce freezes all state.
`timescale 1ns/100ps
`default_nettype none

module iapc_fifo #(
	parameter int W = 25,
	parameter int DEPTH = 16
) (
	// Clock and control
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Fill side
	input wire logic in_valid_i,
	input wire logic [W-1:0] in_data_i,
	output logic in_ready_o,
	// Drain side
	output logic out_valid_o,
	output logic [W-1:0] out_data_o,
	input wire logic out_ready_i
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

	logic [W-1:0] mem_q [DEPTH];
	logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
	logic [AW:0] cnt_q, cnt_d;
	logic push, pop;

	assign in_ready_o = (cnt_q != FULL_CNT);
	assign out_valid_o = (cnt_q != '0);
	assign out_data_o = mem_q[rp_q];

	always_comb begin
		push = in_valid_i && in_ready_o;
		pop = out_valid_o && out_ready_i;
		wp_d = push ? AW'(wp_q + 1'b1) : wp_q;
		rp_d = pop ? AW'(rp_q + 1'b1) : rp_q;
		cnt_d = cnt_q;
		if (push && !pop)
			cnt_d = (AW + 1)'(cnt_q + 1'b1);
		else if (pop && !push)
			cnt_d = (AW + 1)'(cnt_q - 1'b1);
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else if (ce_i) begin
			wp_q <= wp_d;
			rp_q <= rp_d;
			cnt_q <= cnt_d;
			if (push)
				mem_q[wp_q] <= in_data_i;
		end
	end
endmodule // iapc_fifo

`default_nettype wire

/* hdl/iapc_pkg.sv */
// Constants for the audio port configuration block: register map,
// field positions, masks, reset values and timing.
// Assumes a 50 MHz core clock; used by iapc_audio_port, not by iapc_fifo or iapc_sync.
`default_nettype none

package iapc_pkg;
	// Register offsets
	localparam logic [7:0] ADDR_OUT_CFG = 8'h44;
	localparam logic [7:0] ADDR_RX_MODE = 8'h4A;
	localparam logic [7:0] ADDR_TX_FMT = 8'h51;
	localparam logic [7:0] ADDR_IN_CFG = 8'h54;
	localparam logic [7:0] ADDR_TX_MODE = 8'h5A;
	// Writable bits; reserved bits read zero
	localparam logic [7:0] RX_MODE_MASK = 8'hA4;
	localparam logic [7:0] OUT_CFG_MASK = 8'h4F;
	localparam logic [7:0] IN_CFG_MASK = 8'hBF;
	localparam logic [7:0] TX_MODE_MASK = 8'hEF;
	localparam logic [7:0] TX_FMT_MASK = 8'h01;
	localparam logic [7:0] REG_RESET = 8'h00;
	// Field positions
	localparam int MASTER_BIT = 7;
	localparam int LEN_HI = 5;
	localparam int LEN_LO = 4;
	localparam int MUTE_BIT = 6;
	localparam int POL_BIT = 3;
	localparam int EDGE_BIT = 2;
	localparam int DELAY_BIT = 1;
	localparam int JUST_BIT = 0;
	localparam int RXM_PD_BIT = 7;
	localparam int RXM_RF_BIT = 5;
	localparam int RXM_SPDIF_BIT = 2;
	localparam int TXM_SPDIF_BIT = 2;
	localparam int TXM_MCLK_HI = 1;
	localparam int TXM_MCLK_LO = 0;
	localparam int FMT_COMPAND_BIT = 0;
	// Field codes
	localparam logic [1:0] LEN_16 = 2'h0;
	localparam logic [1:0] LEN_24 = 2'h2;
	localparam logic [1:0] MCLK_OFF = 2'h0;
	localparam logic [1:0] MCLK_48K = 2'h1;
	localparam logic [1:0] MCLK_44K = 2'h2;
	// Audio word layout
	localparam int SAMPLE_W = 24;
	localparam int FIFO_W = SAMPLE_W + 1;
	localparam int FIFO_DEPTH = 16;
	localparam logic [4:0] BITS_24 = 5'h18;
	localparam logic [4:0] BITS_16 = 5'h10;
	localparam logic [4:0] SLOT_LAST = 5'h1F;
	localparam logic [7:0] PAD_ZERO = 8'h00;
	// Timing, in picoseconds; half periods in core clock cycles
	localparam int CLK_PERIOD_PS = 20000;
	localparam int BCLK_PERIOD_PS = 160000;
	localparam int MCLK_48K_PERIOD_PS = 81380;
	localparam int MCLK_44K_PERIOD_PS = 88577;
	localparam int MCLK_32K_PERIOD_PS = 122070;
	localparam logic [3:0] BCLK_HALF_CYC = 4'(BCLK_PERIOD_PS / (2 * CLK_PERIOD_PS));
	localparam logic [3:0] MCLK_48K_HALF = 4'(MCLK_48K_PERIOD_PS / (2 * CLK_PERIOD_PS));
	localparam logic [3:0] MCLK_44K_HALF = 4'(MCLK_44K_PERIOD_PS / (2 * CLK_PERIOD_PS));
	localparam logic [3:0] MCLK_32K_HALF = 4'(MCLK_32K_PERIOD_PS / (2 * CLK_PERIOD_PS));

	typedef enum logic {OUT_IDLE, OUT_RUN} iapc_out_state_e;
endpackage

`default_nettype wire

/* hdl/iapc_sync.sv */
// Three-stage pin synchroniser, one stage chain per bit.
// Output follows once the second and third stages agree.
`timescale 1ns/100ps
`default_nettype none

module iapc_sync #(
	parameter int W = 3
) (
	// Clock and control
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Pins in, clean levels out
	input wire logic [W-1:0] pin_i,
	output logic [W-1:0] level_o
);
	genvar gi;
	generate
		for (gi = 0; gi < W; gi++) begin : g_bit
			logic s1_q, s2_q, s3_q, lvl_q, lvl_d;
			always_comb begin
				lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
			end
			always_ff @(posedge core_clk_i) begin
				if (rst_i) begin
					s1_q <= 1'b0;
					s2_q <= 1'b0;
					s3_q <= 1'b0;
					lvl_q <= 1'b0;
				end else if (ce_i) begin
					s1_q <= pin_i[gi];
					s2_q <= s1_q;
					s3_q <= s2_q;
					lvl_q <= lvl_d;
				end
			end
			assign level_o[gi] = lvl_q;
		end
	endgenerate
endmodule // iapc_sync

`default_nettype wire

/* tb/iapc_audio_port_tb.sv */
// Testbench for the audio port: registers, link events, mute, clocks, buffer.
// Assumes iapc_pkg and the I2S source model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module iapc_audio_port_tb;
	logic clk = 0, rst = 1, src_en = 0, rwr = 0, rrd = 0, cwr = 0, crd = 0, rcf = 0, loc = 0;
	logic ce = 1;
	logic [7:0] ra = 0, rw = 0, ca = 0, cw = 0, rdat, cdat, xdat;
	logic xv, pd, rfe, spo, cmp, mclk, ibo, iboe, iwo, iwoe, obc, ows, osd, frdy, ovr, bclk, ws, sd;
	logic [7:0] q[$];
	logic rp = 0, cp = 0;
	int error_cnt = 0, n_tests = 0, cyc = 0;
	logic [7:0] adr[5] = '{iapc_pkg::ADDR_OUT_CFG, iapc_pkg::ADDR_RX_MODE, iapc_pkg::ADDR_TX_FMT,
		iapc_pkg::ADDR_IN_CFG, iapc_pkg::ADDR_TX_MODE};
	logic [7:0] msk[5] = '{8'h4F, 8'hA4, 8'h01, 8'hBF, 8'hEF};
	always #10 clk = ~clk;
	iapc_audio_port i_dut (.core_clk_i(clk), .rst_i(rst), .ce_i(ce),
		.reg_addr_i(ra), .reg_wdata_i(rw), .reg_wr_i(rwr), .reg_rd_i(rrd), .reg_rdata_o(rdat),
		.ctl_addr_i(ca), .ctl_wdata_i(cw), .ctl_wr_i(cwr), .ctl_rd_i(crd), .ctl_rdata_o(cdat),
		.link_reconfig_i(rcf), .link_locate_i(loc), .rx_mode_xfer_valid_o(xv),
		.rx_mode_xfer_data_o(xdat), .rx_power_down_o(pd), .rf_enable_o(rfe),
		.spdif_out_en_o(spo), .tx_compand_o(cmp), .mclk_o(mclk), .in_bclk_i(bclk),
		.in_ws_i(ws), .in_sd_i(sd), .in_bclk_o(ibo), .in_bclk_oe_o(iboe), .in_ws_o(iwo),
		.in_ws_oe_o(iwoe), .out_bclk_o(obc), .out_ws_o(ows), .out_sd_o(osd),
		.fifo_ready_o(frdy), .overrun_o(ovr));
	iapc_i2s_src i_src (.en_i(src_en), .bclk_o(bclk), .ws_o(ws), .sd_o(sd));
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		n_tests++;
		if (s !== e) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic report_and_stop();
		$display("errors=%0d checks=%0d", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// One strobe on either port: c selects the radio port, w a write
	task automatic acc(input bit c, input bit w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		ra <= a;
		ca <= a;
		rw <= d;
		cw <= d;
		rwr <= !c && w;
		rrd <= !c && !w;
		cwr <= c && w;
		crd <= c && !w;
		@(posedge clk);
		rwr <= 1'b0;
		rrd <= 1'b0;
		cwr <= 1'b0;
		crd <= 1'b0;
	endtask
	task automatic rd(input bit c, input logic [7:0] a, input logic [7:0] e);
		q.push_back(e);
		acc(c, 1'b0, a, 8'h00);
	endtask
	task automatic pulse(input bit r);
		@(posedge clk);
		rcf <= r;
		loc <= !r;
		@(posedge clk);
		rcf <= 1'b0;
		loc <= 1'b0;
	endtask
	task automatic ones(input int n, ref logic s, output int k);
		k = 0;
		repeat (n) begin
			@(negedge clk);
			k += int'(s === 1'b1);
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	// Result watcher: oldest note against each result
	always @(posedge clk) begin
		rp <= rrd;
		cp <= crd;
		cyc++;
		if (cyc == 30000) begin
			error_cnt++;
			report_and_stop();
		end
	end
	always @(negedge clk) begin
		if (rp) chk(rdat, q.pop_front());
		if (cp) chk(cdat, q.pop_front());
		if (xv) chk(xdat, q.pop_front());
	end
	initial begin
		int k;
		logic [7:0] d;
		void'($urandom(35));
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		acc(0, 1, 8'h60, 8'hFF);
		rd(0, 8'h60, 8'h00); // Unmapped
		foreach (adr[i]) begin
			rd(0, adr[i], 8'h00);
			d = 8'($urandom);
			acc(0, 1, adr[i], d);
			rd(0, adr[i], d & msk[i]);
			acc(0, 1, adr[i], 8'h00);
		end
		acc(0, 1, iapc_pkg::ADDR_RX_MODE, 8'hA4);
		@(negedge clk) chk({5'h0, pd, rfe, spo}, 8'h07);
		acc(1, 1, iapc_pkg::ADDR_RX_MODE, 8'h20);
		rd(1, iapc_pkg::ADDR_RX_MODE, 8'h20);
		acc(1, 1, iapc_pkg::ADDR_IN_CFG, 8'h80);
		rd(0, iapc_pkg::ADDR_IN_CFG, 8'h00);
		q.push_back(8'h20);
		pulse(0);
		foreach (msk[i]) begin
			d = (i % 2) ? 8'h80 : 8'h00;
			acc(0, 1, iapc_pkg::ADDR_IN_CFG, d);
			@(negedge clk) chk({6'h0, iboe, iwoe}, {6'h0, d[7], d[7]});
		end
		acc(0, 1, iapc_pkg::ADDR_IN_CFG, 8'h80);
		ones(64, ibo, k);
		chk(8'(k), 8'h20);
		acc(0, 1, iapc_pkg::ADDR_IN_CFG, 8'h00);
		acc(0, 1, iapc_pkg::ADDR_TX_MODE, 8'h05); // S/PDIF, rate field still set
		ones(40, mclk, k);
		chk(8'(k), 8'h00);
		acc(0, 1, iapc_pkg::ADDR_TX_MODE, 8'h01);
		ones(40, mclk, k);
		chk({7'h0, k > 0}, 8'h01);
		acc(0, 1, iapc_pkg::ADDR_TX_FMT, 8'h01);
		@(negedge clk) chk({7'h0, cmp}, 8'h00);
		pulse(1);
		@(negedge clk) chk({7'h0, cmp}, 8'h01);
		@(posedge clk) ce <= 1'b0;
		acc(0, 1, iapc_pkg::ADDR_TX_FMT, 8'h00);
		ce <= 1'b1;
		rd(0, iapc_pkg::ADDR_TX_FMT, 8'h01);
		src_en <= 1'b1;
		acc(0, 1, iapc_pkg::ADDR_OUT_CFG, 8'h40);
		ones(2000, osd, k);
		chk(8'(k), 8'h00);
		acc(0, 1, iapc_pkg::ADDR_RX_MODE, 8'hA0);
		repeat (5000) @(posedge clk);
		@(negedge clk) chk({6'h0, frdy, ovr}, 8'h01); // Full, sample dropped
		src_en <= 1'b0;
		acc(0, 1, iapc_pkg::ADDR_RX_MODE, 8'h20);
		repeat (5000) @(posedge clk);
		@(negedge clk) chk({6'h0, frdy, ovr}, 8'h03); // Drained, overrun sticky
		ones(64, obc, k);
		chk(8'(k), 8'h20);
		ones(512, ows, k);
		chk(8'(k >> 2), 8'h40);
		report_and_stop();
	end
endmodule // iapc_audio_port_tb
`default_nettype wire

/* tb/iapc_i2s_src.sv */
// I2S source model driving the capture pins in slave mode.
// Assumes the port samples data on the rising bit clock.
`timescale 1ns/100ps
`default_nettype none
module iapc_i2s_src (
	// Control
	input wire logic en_i,
	// Pins
	output logic bclk_o,
	output logic ws_o,
	output logic sd_o
);
	int n;
	initial begin
		bclk_o = 1'b0;
		ws_o = 1'b0;
		sd_o = 1'b0;
		n = 0;
		forever begin
			#80;
			if (en_i) begin
				bclk_o = ~bclk_o;
				if (!bclk_o) begin // Change on falling, valid at rising
					sd_o = 1'($urandom);
					n = (n + 1) % 32;
					if (n == 0) ws_o = ~ws_o;
				end
			end else begin
				bclk_o = 1'b0;
				sd_o = ~sd_o; // Idle data not held
			end
		end
	end
endmodule // iapc_i2s_src
`default_nettype wire
